/* rtl/adc_ctrl_defs.vh */
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// Serial configuration word
`define CFG_WIDTH 16
`define CFG_BITS_SEEN 5'h10
`define CFG_DONE 5'h11
`define CFG_GAIN_A_LSB 0
`define CFG_GAIN_B_LSB 5
`define CFG_GAIN_WIDTH 5
`define CFG_SINGLE_BUS_BIT 11
`define CFG_CLK_RATE_BIT 12
`define CFG_TWOS_BIT 13
`define CFG_RESET 16'h0000

// Pipeline latency in input clock cycles
`define LAT_DUAL_80 4'h8
`define LAT_DUAL_40 4'h4
`define LAT_SINGLE_A 4'h8
`define LAT_SINGLE_B 4'h9

// Gain takes effect on this many sample ticks after a write
`define GAIN_SYNC_TICKS 2'h2

// Bus register byte offsets
`define REG_CONFIG 4'h0
`define REG_STATUS 4'h4

// Status register fields
`define STAT_VREF_OFF 0
`define STAT_SLEEP 1
`define STAT_CLK_RATE 2
`define STAT_SINGLE_BUS 3
`define STAT_INCOMPLETE 4
`define STAT_GAIN_PEND 5

`endif

/* rtl/sample_delay_line.v */
`timescale 1ns/1ps
`default_nettype none

// Shift memory of captured sample pairs with two registered read taps
module sample_delay_line #(
	parameter WIDTH = 21,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire i_clk_sys,
	input wire i_rst,
	// Write side
	input wire i_shift,
	input wire [WIDTH-1:0] i_din,
	// Read taps
	input wire [AW-1:0] i_tap_a,
	input wire [AW-1:0] i_tap_b,
	output reg [WIDTH-1:0] o_tap_a,
	output reg [WIDTH-1:0] o_tap_b
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
integer k;

// Cleared on reset so stale valid flags never reach the bus
always @(posedge i_clk_sys) begin
	if (i_rst) begin
		for (k = 0; k < DEPTH; k = k + 1) begin
			mem[k] <= {WIDTH{1'b0}};
		end
	end else if (i_shift) begin
		mem[0] <= i_din;
		for (k = 1; k < DEPTH; k = k + 1) begin
			mem[k] <= mem[k-1];
		end
	end
end

// Read data from a register
always @(posedge i_clk_sys) begin
	if (i_rst) begin
		o_tap_a <= {WIDTH{1'b0}};
		o_tap_b <= {WIDTH{1'b0}};
	end else begin
		o_tap_a <= mem[i_tap_a];
		o_tap_b <= mem[i_tap_b];
	end
end

endmodule

`default_nettype wire

/* rtl/dual_adc_output_timing_control.v */
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.vh"

module dual_adc_output_timing_control #(
	parameter DATA_W = 10
) (
	// System clock and reset
	input wire i_clk_sys,
	input wire i_rst,
	// Control pins
	input wire i_sample_clk,
	input wire i_sleep_pin,
	input wire i_internal_vref_off,
	input wire i_output_enable_n,
	// Serial configuration port
	input wire i_serial_clk,
	input wire i_serial_select_n,
	input wire i_config_serial_input,
	// Converter core results
	input wire [DATA_W-1:0] i_chan_a_word,
	input wire [DATA_W-1:0] i_chan_b_word,
	// Avalon-MM slave
	input wire [3:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	output reg [31:0] o_avs_readdata,
	output reg o_avs_waitrequest,
	// Primary and secondary output buses
	output reg [DATA_W-1:0] o_primary_output_bus,
	output reg o_primary_output_bus_oe,
	output reg [DATA_W-1:0] o_secondary_output_bus,
	output reg o_secondary_output_bus_oe,
	// Output latch clock pair
	output reg o_output_latch_clock,
	output reg o_output_latch_clock_n,
	output reg o_output_latch_clock_oe,
	// Core controls
	output reg o_internal_sample_clock,
	output reg o_sample_strobe,
	output reg o_powered_down,
	output reg o_vref_disable,
	output reg o_twos_complement,
	output reg [4:0] o_gain_a,
	output reg [4:0] o_gain_b
);

localparam WORD_W = 2 * DATA_W + 1;

// Two-stage synchronisers plus a third stage for edge detection
reg [2:0] clk_sync_reg;
reg [2:0] sclk_sync_reg;
reg [2:0] ssel_sync_reg;
reg [1:0] sdi_sync_reg;
reg [1:0] sleep_sync_reg;
reg [1:0] vref_sync_reg;
reg [1:0] oen_sync_reg;

always @(posedge i_clk_sys) begin
	if (i_rst) begin
		clk_sync_reg <= 3'h0;
		sclk_sync_reg <= 3'h0;
		ssel_sync_reg <= 3'h7;
		sdi_sync_reg <= 2'h0;
		sleep_sync_reg <= 2'h0;
		vref_sync_reg <= 2'h0;
		oen_sync_reg <= 2'h3;
	end else begin
		clk_sync_reg <= {clk_sync_reg[1:0], i_sample_clk};
		sclk_sync_reg <= {sclk_sync_reg[1:0], i_serial_clk};
		ssel_sync_reg <= {ssel_sync_reg[1:0], i_serial_select_n};
		sdi_sync_reg <= {sdi_sync_reg[0], i_config_serial_input};
		sleep_sync_reg <= {sleep_sync_reg[0], i_sleep_pin};
		vref_sync_reg <= {vref_sync_reg[0], i_internal_vref_off};
		oen_sync_reg <= {oen_sync_reg[0], i_output_enable_n};
	end
end

wire clk_level = clk_sync_reg[1];
wire clk_rise = clk_sync_reg[1] & ~clk_sync_reg[2];
wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
wire ssel_rise = ssel_sync_reg[1] & ~ssel_sync_reg[2];
wire ssel_active = ~ssel_sync_reg[1];
wire sleep = sleep_sync_reg[1];

// Configuration state
reg [`CFG_WIDTH-1:0] cfg_reg;
reg [`CFG_WIDTH-1:0] shift_reg;
reg [4:0] bit_cnt_reg;
reg incomplete_reg;
reg [1:0] gain_wait_reg;
reg commit;
reg [`CFG_WIDTH-1:0] commit_word;
reg sample_tick;

wire clk_rate_sel = cfg_reg[`CFG_CLK_RATE_BIT];
wire single_bus = cfg_reg[`CFG_SINGLE_BUS_BIT];
wire bus_write = i_avs_write & ~o_avs_waitrequest;
wire bus_cfg_write = bus_write & (i_avs_address == `REG_CONFIG);

// Pick which source finishes a write this cycle
always @* begin
	commit = 1'b0;
	commit_word = shift_reg;
	if ((ssel_rise | (ssel_active & sclk_rise)) &&
	    bit_cnt_reg == `CFG_BITS_SEEN) begin
		commit = 1'b1;
	end else if (bus_cfg_write) begin
		commit = 1'b1;
		commit_word = i_avs_writedata[`CFG_WIDTH-1:0];
	end
end

// Serial shifter; bits beyond the sixteenth are ignored until select rises
always @(posedge i_clk_sys) begin
	if (i_rst) begin
		shift_reg <= `CFG_RESET;
		bit_cnt_reg <= 5'h0;
		incomplete_reg <= 1'b0;
		cfg_reg <= `CFG_RESET;
	end else begin
		if (commit) begin
			cfg_reg <= commit_word;
		end
		if (ssel_rise) begin
			bit_cnt_reg <= 5'h0;
			if (bit_cnt_reg < `CFG_BITS_SEEN) begin
				incomplete_reg <= 1'b1;
			end else begin
				incomplete_reg <= 1'b0;
			end
		end else if (commit && bit_cnt_reg == `CFG_BITS_SEEN) begin
			bit_cnt_reg <= `CFG_DONE;
			incomplete_reg <= 1'b0;
		end else if (ssel_active && sclk_fall &&
		             bit_cnt_reg < `CFG_BITS_SEEN) begin
			shift_reg <= {shift_reg[`CFG_WIDTH-2:0], sdi_sync_reg[1]};
			bit_cnt_reg <= bit_cnt_reg + 5'h1;
		end
	end
end

// Gain is held back to a sample boundary to avoid mid-sample steps
always @(posedge i_clk_sys) begin
	if (i_rst) begin
		gain_wait_reg <= 2'h0;
		o_gain_a <= 5'h0;
		o_gain_b <= 5'h0;
	end else if (commit) begin
		gain_wait_reg <= `GAIN_SYNC_TICKS;
	end else if (sample_tick && gain_wait_reg != 2'h0) begin
		gain_wait_reg <= gain_wait_reg - 2'h1;
		if (gain_wait_reg == 2'h1) begin
			o_gain_a <= cfg_reg[`CFG_GAIN_A_LSB +: `CFG_GAIN_WIDTH];
			o_gain_b <= cfg_reg[`CFG_GAIN_B_LSB +: `CFG_GAIN_WIDTH];
		end
	end
end

// Sample pacing from input clock edges
reg phase_reg;
wire every_edge = clk_rate_sel & ~single_bus;

always @* begin
	sample_tick = clk_rise & (every_edge | ~phase_reg) & ~sleep;
end

always @(posedge i_clk_sys) begin
	if (i_rst) begin
		phase_reg <= 1'b0;
	end else if (clk_rise) begin
		phase_reg <= every_edge ? 1'b0 : ~phase_reg;
	end
end

// Latency taps per arrangement
reg [3:0] tap_a;
reg [3:0] tap_b;

always @* begin
	if (single_bus) begin
		tap_a = `LAT_SINGLE_A;
		tap_b = `LAT_SINGLE_B;
	end else if (clk_rate_sel) begin
		tap_a = `LAT_DUAL_40;
		tap_b = `LAT_DUAL_40;
	end else begin
		tap_a = `LAT_DUAL_80;
		tap_b = `LAT_DUAL_80;
	end
end

wire [WORD_W-1:0] tap_a_word;
wire [WORD_W-1:0] tap_b_word;

// Delay line shifts once per input clock rising edge
sample_delay_line #(
	.WIDTH(WORD_W),
	.DEPTH(16),
	.AW(4)
) u_delay (
	.i_clk_sys(i_clk_sys),
	.i_rst(i_rst),
	.i_shift(clk_rise),
	.i_din({sample_tick, i_chan_b_word, i_chan_a_word}),
	.i_tap_a(tap_a),
	.i_tap_b(tap_b),
	.o_tap_a(tap_a_word),
	.o_tap_b(tap_b_word)
);

// Output coding: offset binary or two's complement
function [DATA_W-1:0] fmt;
	input [DATA_W-1:0] w;
	input twos;
	begin
		fmt = {w[DATA_W-1] ^ twos, w[DATA_W-2:0]};
	end
endfunction

// Tap register holds the shifted word two cycles after the shift;
// one stage less would present every word an input clock late
reg [1:0] rise_d_reg;

always @(posedge i_clk_sys) begin
	if (i_rst) begin
		rise_d_reg <= 2'h0;
	end else begin
		rise_d_reg <= {rise_d_reg[0], clk_rise};
	end
end

// Output data update at input clock edges
always @(posedge i_clk_sys) begin
	if (i_rst) begin
		o_primary_output_bus <= {DATA_W{1'b0}};
		o_secondary_output_bus <= {DATA_W{1'b0}};
	end else if (rise_d_reg[1]) begin
		if (single_bus) begin
			if (tap_a_word[WORD_W-1]) begin
				o_primary_output_bus <=
					fmt(tap_a_word[DATA_W-1:0], o_twos_complement);
			end else if (tap_b_word[WORD_W-1]) begin
				o_primary_output_bus <=
					fmt(tap_b_word[2*DATA_W-1:DATA_W], o_twos_complement);
			end
		end else begin
			if (tap_a_word[WORD_W-1]) begin
				o_primary_output_bus <=
					fmt(tap_a_word[DATA_W-1:0], o_twos_complement);
				o_secondary_output_bus <=
					fmt(tap_b_word[2*DATA_W-1:DATA_W], o_twos_complement);
			end
		end
	end
end

// Drive enables; limited by synchroniser delay, not by the pad
always @(posedge i_clk_sys) begin
	if (i_rst) begin
		o_primary_output_bus_oe <= 1'b0;
		o_secondary_output_bus_oe <= 1'b0;
		o_output_latch_clock_oe <= 1'b0;
		o_powered_down <= 1'b0;
		o_vref_disable <= 1'b0;
	end else begin
		o_primary_output_bus_oe <= ~oen_sync_reg[1] & ~sleep;
		o_secondary_output_bus_oe <= ~oen_sync_reg[1] & ~sleep & ~single_bus;
		o_output_latch_clock_oe <= ~oen_sync_reg[1] & ~sleep;
		o_powered_down <= sleep;
		o_vref_disable <= vref_sync_reg[1];
	end
end

// Internal and latch clocks
always @(posedge i_clk_sys) begin
	if (i_rst) begin
		o_internal_sample_clock <= 1'b0;
		o_output_latch_clock <= 1'b0;
		o_output_latch_clock_n <= 1'b1;
		o_sample_strobe <= 1'b0;
		o_twos_complement <= 1'b0;
	end else begin
		o_internal_sample_clock <= every_edge ? clk_level : ~phase_reg;
		if (single_bus && clk_rate_sel) begin
			o_output_latch_clock <= clk_level;
			o_output_latch_clock_n <= ~clk_level;
		end else begin
			o_output_latch_clock <= every_edge ? clk_level : ~phase_reg;
			o_output_latch_clock_n <= every_edge ? ~clk_level : phase_reg;
		end
		o_sample_strobe <= sample_tick;
		o_twos_complement <= cfg_reg[`CFG_TWOS_BIT];
	end
end

// Avalon slave: one wait cycle, then the answer
always @(posedge i_clk_sys) begin
	if (i_rst) begin
		o_avs_waitrequest <= 1'b1;
		o_avs_readdata <= 32'h0;
	end else if ((i_avs_read | i_avs_write) && o_avs_waitrequest) begin
		o_avs_waitrequest <= 1'b0;
		case (i_avs_address)
			`REG_CONFIG: o_avs_readdata <= {16'h0, cfg_reg};
			`REG_STATUS: o_avs_readdata <= {26'h0,
				gain_wait_reg != 2'h0, incomplete_reg, single_bus,
				clk_rate_sel, sleep, vref_sync_reg[1]};
			default: o_avs_readdata <= 32'h0;
		endcase
	end else begin
		o_avs_waitrequest <= 1'b1;
	end
end

endmodule

`default_nettype wire

/* test/adc_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the converter control block
module adc_ctrl_asserts (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Pins and bus
	input wire logic i_sleep_pin,
	input wire logic i_internal_vref_off,
	input wire logic i_output_enable_n,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	// Outputs watched
	input wire logic o_primary_output_bus_oe,
	input wire logic o_secondary_output_bus_oe,
	input wire logic o_output_latch_clock,
	input wire logic o_output_latch_clock_n,
	input wire logic o_output_latch_clock_oe,
	input wire logic o_sample_strobe,
	input wire logic o_powered_down,
	input wire logic o_vref_disable
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// Pins pass two sync stages, so five cycles is a safe bound
	chk_sleep_down: assert property (
		i_sleep_pin [*5] |-> o_powered_down && !o_primary_output_bus_oe)
		else $error("sleep pin did not power down");
	chk_asleep_quiet: assert property (
		o_powered_down && $past(o_powered_down) |-> !o_sample_strobe)
		else $error("sample taken while asleep");
	chk_vref_off: assert property (
		i_internal_vref_off [*5] |-> o_vref_disable)
		else $error("reference not switched off");
	chk_vref_on: assert property (
		(!i_internal_vref_off) [*5] |-> !o_vref_disable)
		else $error("reference switched off while pin low");
	chk_oe_float: assert property (
		i_output_enable_n [*5] |-> !o_primary_output_bus_oe &&
		!o_secondary_output_bus_oe && !o_output_latch_clock_oe)
		else $error("outputs driven while disabled");
	chk_latch_pair: assert property (
		o_output_latch_clock_oe |->
		o_output_latch_clock != o_output_latch_clock_n)
		else $error("latch clock pair not complementary");
	chk_sec_bus: assert property (
		o_secondary_output_bus_oe |-> o_primary_output_bus_oe)
		else $error("secondary bus driven alone");
	chk_strobe_gap: assert property (
		o_sample_strobe |=> !o_sample_strobe [*7])
		else $error("samples closer than one input period");
	chk_bus_answer: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=>
		!o_avs_waitrequest ##1 o_avs_waitrequest)
		else $error("bus answer not one cycle");
	chk_upper_zero: assert property (
		!o_avs_waitrequest && i_avs_read |-> o_avs_readdata[31:16] == 0)
		else $error("upper read bits not zero");
	cov_strobe: cover property (o_sample_strobe);
	cov_sleep: cover property (o_powered_down);
	cov_single: cover property (o_primary_output_bus_oe &&
		!o_secondary_output_bus_oe);
endmodule
`default_nettype wire

/* test/serial_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial configuration port
module serial_host_model (
	// Clock
	input wire logic i_clk_sys,
	// Serial pins
	output logic o_serial_clk,
	output logic o_serial_select_n,
	output logic o_config_serial_input
);
	localparam int HALF = 4;
	// Clock idles low between frames
	initial begin
		o_serial_clk = 1'b0;
		o_serial_select_n = 1'b1;
		o_config_serial_input = 1'b0;
	end
	// Writes n leading bits of w; n below 16 aborts the write
	task automatic send(input logic [15:0] w, input int n);
		int i;
		o_serial_select_n <= 1'b0;
		for (i = 15; i > 15 - n; i--) begin
			repeat (HALF) @(posedge i_clk_sys);
			o_serial_clk <= 1'b1;
			// MSB first, held over high phase
			o_config_serial_input <= w[i];
			repeat (HALF) @(posedge i_clk_sys);
			o_serial_clk <= 1'b0;
		end
		repeat (HALF) @(posedge i_clk_sys);
		o_serial_clk <= 1'b1;
		repeat (HALF) @(posedge i_clk_sys);
		o_serial_select_n <= 1'b1;
		// Released line shows no stale bit
		o_config_serial_input <= ~o_config_serial_input;
		repeat (HALF) @(posedge i_clk_sys);
		o_serial_clk <= 1'b0;
		repeat (HALF) @(posedge i_clk_sys);
	endtask
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	// Stimulus
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic i_sample_clk = 1'b0;
	logic i_sleep_pin = 1'b0;
	logic i_internal_vref_off = 1'b0;
	logic i_output_enable_n = 1'b0;
	logic [9:0] wa = 10'h000;
	logic [9:0] wb = 10'h000;
	logic hold = 1'b0;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] q;
	integer seed = 32'hb580;
	int bad_count = 0;
	int cmp_count = 0;
	// Observed
	wire logic sck, ssn, config_serial_input, wq, poe, soe, lc, lcn, loe, isc, stb, pd, vd, tw;
	wire logic [31:0] rdat;
	wire logic [9:0] pbus, sbus;
	wire logic [4:0] ga, gb;
	always #50 i_clk_sys = ~i_clk_sys;
	// Input clock eight system periods long, edges midway between system rising edges
	always #400 i_sample_clk = ~i_sample_clk;
	// Random core words unless a scenario holds them
	always @(posedge i_clk_sys) if (!hold) {wb, wa} <= 20'($random(seed));
	serial_host_model u_serial_host_model (.i_clk_sys(i_clk_sys),
		.o_serial_clk(sck), .o_serial_select_n(ssn),
		.o_config_serial_input(config_serial_input));
	dual_adc_output_timing_control u_dual_adc_output_timing_control (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sample_clk(i_sample_clk),
		.i_sleep_pin(i_sleep_pin), .i_internal_vref_off(i_internal_vref_off),
		.i_output_enable_n(i_output_enable_n), .i_serial_clk(sck),
		.i_serial_select_n(ssn), .i_config_serial_input(config_serial_input),
		.i_chan_a_word(wa), .i_chan_b_word(wb), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wq),
		.o_primary_output_bus(pbus), .o_primary_output_bus_oe(poe),
		.o_secondary_output_bus(sbus), .o_secondary_output_bus_oe(soe),
		.o_output_latch_clock(lc), .o_output_latch_clock_n(lcn),
		.o_output_latch_clock_oe(loe), .o_internal_sample_clock(isc),
		.o_sample_strobe(stb), .o_powered_down(pd), .o_vref_disable(vd),
		.o_twos_complement(tw), .o_gain_a(ga), .o_gain_b(gb));
	// Expected word with the sign bit flipped in twos mode
	function automatic logic [9:0] exp_word(logic [9:0] w, logic t);
		return t ? w ^ 10'h200 : w;
	endfunction
	// Pipeline depth in input clocks for bus select, rate and channel
	function automatic int exp_lat(logic sb, logic rate, logic chb);
		if (sb) return chb ? `LAT_SINGLE_B : `LAT_SINGLE_A;
		return rate ? `LAT_DUAL_40 : `LAT_DUAL_80;
	endfunction
	// One bus access; holds until waitrequest is seen low
	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		// Waitrequest seen low ends this wait; otherwise the watchdog does
		do begin
			@(posedge i_clk_sys);
		end while (wq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge i_clk_sys);
	endtask
	task automatic print_verdict();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		bad_count++;
		print_verdict();
	end
	initial begin
		logic [15:0] w;
		int k, nl, ns, ni, n, na, nb;
		logic pl, pi;
		logic [31:0] r;
		repeat (12) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		xfer(0, `REG_CONFIG, 0);
		`CHK(q, 32'h0)
		xfer(0, 4'h8, 0);
		`CHK(q, 32'h0)
		w = 16'($random(seed));
		u_serial_host_model.send(w, 16);
		xfer(0, `REG_CONFIG, 0);
		`CHK(q[13:0], w[13:0])
		u_serial_host_model.send(~w, 10);
		xfer(1, 4'hc, 32'hffff);
		xfer(0, `REG_CONFIG, 0);
		`CHK(q[13:0], w[13:0])
		xfer(0, `REG_STATUS, 0);
		`CHK(q[`STAT_INCOMPLETE], 1'b1)
		// Coding and gains still from the last complete word
		`CHK({tw, ga, gb}, {w[13], w[4:0], w[9:5]})
		// Every arrangement: clocks counted over eight input periods
		for (k = 0; k < 4; k++) begin
			xfer(1, `REG_CONFIG, {19'h0, k[0], k[1], 11'h0});
			xfer(0, `REG_STATUS, 0);
			`CHK(q[3:2], {k[1], k[0]})
			repeat (40) @(posedge i_clk_sys);
			{nl, ns, ni, pl, pi} = {lc, isc};
			repeat (64) begin
				@(posedge i_clk_sys);
				nl += (lc !== pl);
				ni += (isc !== pi);
				ns += (stb === 1'b1);
				{pl, pi} = {lc, isc};
			end
			`CHK(nl > 12, k[0])
			`CHK(ni > 12, k == 1)
			`CHK(ns > 6, k == 1)
			`CHK({poe, soe}, {1'b1, k < 2})
			// Latency: one marked pair after a steady zero stream
			hold <= 1'b1;
			{wb, wa} <= 20'h0;
			repeat (100) @(posedge i_clk_sys);
			r = $random(seed);
			do @(posedge i_clk_sys); while (stb !== 1'b1);
			// Distinct, non-zero words so no earlier output matches
			{wb, wa} <= {1'b0, r[17:9] | 9'h001, 1'b1, r[8:0]};
			do @(posedge i_clk_sys); while (stb !== 1'b1);
			na = 0;
			nb = 0;
			for (n = 1; n <= 100; n++) begin
				@(posedge i_clk_sys);
				if (na == 0 && pbus === wa) na = n;
				if (nb == 0 && (k[1] ? pbus : sbus) === wb) nb = n;
			end
			// Eight system cycles per input clock
			`CHK(na / 8, exp_lat(k[1], k[0], 0))
			`CHK(nb / 8, exp_lat(k[1], k[0], 1))
		end
		hold <= 1'b1;
		xfer(1, `REG_CONFIG, 32'h2000);
		{wb, wa} <= 20'($random(seed));
		repeat (200) @(posedge i_clk_sys);
		`CHK({pbus, sbus}, {exp_word(wa, 1), exp_word(wb, 1)})
		i_sleep_pin <= 1'b1;
		i_internal_vref_off <= 1'b1;
		repeat (8) @(posedge i_clk_sys);
		`CHK({poe, soe, loe, pd, vd}, 5'b00011)
		xfer(0, `REG_STATUS, 0);
		`CHK(q[1:0], 2'b11)
		i_sleep_pin <= 1'b0;
		i_internal_vref_off <= 1'b0;
		i_output_enable_n <= 1'b1;
		repeat (8) @(posedge i_clk_sys);
		`CHK({poe, soe, loe, pd, vd}, 5'b00000)
		i_output_enable_n <= 1'b0;
		repeat (8) @(posedge i_clk_sys);
		`CHK({poe, soe, loe}, 3'b111)
		print_verdict();
	end
endmodule
bind dual_adc_output_timing_control adc_ctrl_asserts u_adc_ctrl_asserts (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sleep_pin(i_sleep_pin),
	.i_internal_vref_off(i_internal_vref_off),
	.i_output_enable_n(i_output_enable_n), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest),
	.o_primary_output_bus_oe(o_primary_output_bus_oe),
	.o_secondary_output_bus_oe(o_secondary_output_bus_oe),
	.o_output_latch_clock(o_output_latch_clock),
	.o_output_latch_clock_n(o_output_latch_clock_n),
	.o_output_latch_clock_oe(o_output_latch_clock_oe),
	.o_sample_strobe(o_sample_strobe), .o_powered_down(o_powered_down),
	.o_vref_disable(o_vref_disable));
`default_nettype wire
